/* src/mscfg_pkg.sv */
// Package for the memory size configuration block: offsets, fields,
// reset values and decoder boundaries.
// Assumes an 8-bit special register bus from the CPU core.
package mscfg_pkg;
   localparam logic [15:0] MEM_SEL_OFS    = 16'hfff0;
   localparam logic [15:0] EXT_SEL_OFS    = 16'hfff4;
   localparam logic [7:0]  MEM_SEL_RST    = 8'hcf;
   localparam logic [7:0]  EXT_SEL_RST    = 8'h0c;
   localparam logic [7:0]  MEM_SEL_MASK   = 8'hef;
   localparam logic [7:0]  EXT_SEL_MASK   = 8'h1f;
   localparam int          DRAM_MSB       = 7;
   localparam int          DRAM_LSB       = 5;
   localparam int          PMEM_MSB       = 3;
   localparam int          PMEM_LSB       = 0;
   localparam int          EXT_MSB        = 4;
   localparam int          EXT_LSB        = 0;
   localparam logic [2:0]  DRAM_1K        = 3'h6;
   localparam logic [3:0]  PMEM_24K       = 4'h6;
   localparam logic [3:0]  PMEM_32K       = 4'h8;
   localparam logic [4:0]  EXT_ZERO       = 5'h0c;
   localparam logic [15:0] PMEM_END_24K   = 16'h5fff;
   localparam logic [15:0] PMEM_END_32K   = 16'h7fff;
   localparam logic [15:0] DRAM_START     = 16'hfb00;
   localparam logic [10:0] DRAM_BYTES_1K  = 11'h400;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mscfg_req_type;

   typedef struct packed {
      logic        pmem_valid;
      logic [15:0] pmem_end;
      logic        dram_valid;
      logic [15:0] dram_start;
      logic [10:0] dram_bytes;
      logic        ext_valid;
      logic [15:0] ext_bytes;
   } mscfg_map_type;
endpackage : mscfg_pkg

/* src/mscfg_reg8.sv */
// One 8-bit configuration register with write mask and reset value.
// Assumes a single synchronous write strobe from the bus decode.
`timescale 1ns/1ps
`default_nettype none
module mscfg_reg8 #(
   parameter logic [7:0] RST  = 8'h00,
   parameter logic [7:0] MASK = 8'hff
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Write side
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // Stored value
   output logic      [7:0] q
);
   logic [7:0] q_r;
   logic [7:0] q_nxt;

   always_comb begin
      q_nxt = q_r;
      if (we) begin
         // Fixed-zero bits never take a written one
         q_nxt = wdata & MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q_r <= RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : mscfg_reg8
`default_nettype wire

/* src/mscfg_top.sv */
// Memory size configuration registers and the memory map they select.
// Assumes the CPU bus is synchronous to clk and issues 8-bit accesses.
`timescale 1ns/1ps
`default_nettype none
module mscfg_top (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Register access
   input  wire mscfg_pkg::mscfg_req_type req,
   output logic                       rd_hit,
   output logic [7:0]                 rdata,
   // Selected memory map
   output mscfg_pkg::mscfg_map_type   map,
   output logic                       cfg_err
);
   logic       mem_we;
   logic       ext_we;
   logic [7:0] mem_q;
   logic [7:0] ext_q;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       hit_r;
   logic       hit_nxt;
   mscfg_pkg::mscfg_map_type map_r;
   mscfg_pkg::mscfg_map_type map_nxt;
   logic [2:0] dram_code;
   logic [3:0] pmem_code;
   logic [4:0] ext_code;

   assign mem_we = req.wr && (req.addr == mscfg_pkg::MEM_SEL_OFS);
   assign ext_we = req.wr && (req.addr == mscfg_pkg::EXT_SEL_OFS);

   mscfg_reg8 #(
      .RST  (mscfg_pkg::MEM_SEL_RST),
      .MASK (mscfg_pkg::MEM_SEL_MASK)
   ) u_mem_sel (
      .clk   (clk),
      .rst_b (rst_b),
      .we    (mem_we),
      .wdata (req.wdata),
      .q     (mem_q)
   );

   mscfg_reg8 #(
      .RST  (mscfg_pkg::EXT_SEL_RST),
      .MASK (mscfg_pkg::EXT_SEL_MASK)
   ) u_ext_sel (
      .clk   (clk),
      .rst_b (rst_b),
      .we    (ext_we),
      .wdata (req.wdata),
      .q     (ext_q)
   );

   assign dram_code = mem_q[mscfg_pkg::DRAM_MSB:mscfg_pkg::DRAM_LSB];
   assign pmem_code = mem_q[mscfg_pkg::PMEM_MSB:mscfg_pkg::PMEM_LSB];
   assign ext_code  = ext_q[mscfg_pkg::EXT_MSB:mscfg_pkg::EXT_LSB];

   // Read data registered one cycle after the read strobe
   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b0;
      if (req.rd && req.addr == mscfg_pkg::MEM_SEL_OFS) begin
         rdata_nxt = mem_q;
         hit_nxt   = 1'b1;
      end else if (req.rd && req.addr == mscfg_pkg::EXT_SEL_OFS) begin
         rdata_nxt = ext_q;
         hit_nxt   = 1'b1;
      end
   end

   // Decode of the selected capacities; prohibited codes map nothing
   always_comb begin
      map_nxt            = '0;
      map_nxt.dram_start = mscfg_pkg::DRAM_START;
      if (dram_code == mscfg_pkg::DRAM_1K) begin
         map_nxt.dram_valid = 1'b1;
         map_nxt.dram_bytes = mscfg_pkg::DRAM_BYTES_1K;
      end
      case (pmem_code)
         mscfg_pkg::PMEM_24K: begin
            map_nxt.pmem_valid = 1'b1;
            map_nxt.pmem_end   = mscfg_pkg::PMEM_END_24K;
         end
         mscfg_pkg::PMEM_32K: begin
            map_nxt.pmem_valid = 1'b1;
            map_nxt.pmem_end   = mscfg_pkg::PMEM_END_32K;
         end
         default: begin
            map_nxt.pmem_valid = 1'b0;
         end
      endcase
      // Zero bytes of extension RAM is the only legal size
      map_nxt.ext_valid = (ext_code == mscfg_pkg::EXT_ZERO);
      map_nxt.ext_bytes = 16'h0000;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
         hit_r   <= 1'b0;
         map_r   <= '0;
      end else begin
         rdata_r <= rdata_nxt;
         hit_r   <= hit_nxt;
         map_r   <= map_nxt;
      end
   end

   assign rdata   = rdata_r;
   assign rd_hit  = hit_r;
   assign map     = map_r;
   // Flags a prohibited setting left in place, e.g. reset value unchanged
   assign cfg_err = !(map_r.dram_valid && map_r.pmem_valid
                      && map_r.ext_valid);

   // Reset values must stand at the first edge after release
   property mem_rst_p;
      @(posedge clk) $rose(rst_b) |-> (mem_q == mscfg_pkg::MEM_SEL_RST);
   endproperty
   mem_reset_a: assert property (mem_rst_p)
      else $error("memory size register not CFH after reset");

   ext_reset_a: assert property (@(posedge clk)
      $rose(rst_b) |-> (ext_q == mscfg_pkg::EXT_SEL_RST))
      else $error("extension register not 0CH after reset");

   // The map needs one edge after release to show the reset capacities
   map_reset_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      $rose(rst_b) |=> (!map.pmem_valid && map.dram_valid && cfg_err))
      else $error("map not showing reset capacities");

   mem_bit4_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (mem_q & ~mscfg_pkg::MEM_SEL_MASK) == 8'h00)
      else $error("memory size bit 4 not zero");

   ext_top_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (ext_q & ~mscfg_pkg::EXT_SEL_MASK) == 8'h00)
      else $error("extension register upper bits not zero");

   // Bus requests, one per register and direction
   sequence mem_wr_s;
      req.wr && req.addr == mscfg_pkg::MEM_SEL_OFS;
   endsequence
   sequence ext_wr_s;
      req.wr && req.addr == mscfg_pkg::EXT_SEL_OFS;
   endsequence
   sequence mem_rd_s;
      req.rd && req.addr == mscfg_pkg::MEM_SEL_OFS;
   endsequence
   sequence ext_rd_s;
      req.rd && req.addr == mscfg_pkg::EXT_SEL_OFS;
   endsequence

   mem_write_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      mem_wr_s |=> (mem_q == ($past(req.wdata) & mscfg_pkg::MEM_SEL_MASK)))
      else $error("memory size write not stored");

   ext_write_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      ext_wr_s |=> (ext_q == ($past(req.wdata) & mscfg_pkg::EXT_SEL_MASK)))
      else $error("extension size write not stored");

   pmem_end_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (pmem_code == mscfg_pkg::PMEM_32K) |=> (map.pmem_valid
         && map.pmem_end == mscfg_pkg::PMEM_END_32K))
      else $error("32K program end wrong");

   pmem_24k_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (pmem_code == mscfg_pkg::PMEM_24K) |=> (map.pmem_valid
         && map.pmem_end == mscfg_pkg::PMEM_END_24K))
      else $error("24K program end wrong");

   pmem_bad_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (pmem_code != mscfg_pkg::PMEM_24K
       && pmem_code != mscfg_pkg::PMEM_32K) |=> !map.pmem_valid)
      else $error("prohibited program code mapped");

   dram_map_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (dram_code != mscfg_pkg::DRAM_1K) |=> !map.dram_valid)
      else $error("prohibited data RAM code mapped");

   // Sampled reset guard: the map is still cleared on the release edge
   dram_ok_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (rst_b && dram_code == mscfg_pkg::DRAM_1K) |=> (map.dram_valid
         && map.dram_bytes == mscfg_pkg::DRAM_BYTES_1K))
      else $error("1024-byte data RAM not mapped");

   // Data RAM start is fixed once the map has left reset
   dram_start_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (rst_b && $past(rst_b)) |-> (map.dram_start == mscfg_pkg::DRAM_START))
      else $error("data RAM start address wrong");

   ext_map_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (rst_b && ext_code == mscfg_pkg::EXT_ZERO) |=> (map.ext_valid
         && map.ext_bytes == 16'h0000))
      else $error("zero-byte extension RAM not mapped");

   // The error flag must rise for any prohibited extension code
   ext_bad_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      (ext_code != mscfg_pkg::EXT_ZERO) |=> (!map.ext_valid && cfg_err))
      else $error("prohibited extension code not flagged");

   sequence legal_cfg_s;
      rst_b && dram_code == mscfg_pkg::DRAM_1K
         && (pmem_code == mscfg_pkg::PMEM_24K
             || pmem_code == mscfg_pkg::PMEM_32K)
         && ext_code == mscfg_pkg::EXT_ZERO;
   endsequence
   cfg_ok_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      legal_cfg_s |=> !cfg_err)
      else $error("legal sizes flagged as error");

   mem_read_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      mem_rd_s |=> (rd_hit && rdata == $past(mem_q)))
      else $error("memory size register read back wrong");

   read_back_a: assert property (@(posedge clk)
      disable iff (!rst_b)
      ext_rd_s |=> (rd_hit && rdata == $past(ext_q)))
      else $error("extension register read back wrong");
endmodule : mscfg_top
`default_nettype wire

/* test/test_memory_size_config.sv */
// Self-checking bench for the memory size configuration registers.
// Assumes the package and mscfg_top are compiled first; drives req itself.
`timescale 1ns/1ps
`default_nettype none
module test_memory_size_config;
   logic                     clk;
   logic                     rst_b;
   mscfg_pkg::mscfg_req_type req;
   logic                     rd_hit;
   logic [7:0]               rdata;
   mscfg_pkg::mscfg_map_type map;
   logic                     cfg_err;
   int                       n_fail;
   int                       comparisons;

   mscfg_top dut_u (
      .clk     (clk),
      .rst_b   (rst_b),
      .req     (req),
      .rd_hit  (rd_hit),
      .rdata   (rdata),
      .map     (map),
      .cfg_err (cfg_err)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic report_and_stop;
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   // Read data is registered at the taking edge, so look just after it
   task automatic rd(input logic [15:0] a, input logic [7:0] e,
                     input logic h);
      @(posedge clk);
      req.rd   <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk({rd_hit, rdata}, {h, e});
   endtask : rd

   // Map trails the register by one cycle
   task automatic mp(input logic pv, input logic [15:0] pe,
                     input logic dv, input logic er);
      repeat (2) @(posedge clk);
      #1;
      chk({map.pmem_valid, map.dram_valid, cfg_err}, {pv, dv, er});
      if (pv) chk(map.pmem_end, pe);
      if (dv) chk({map.dram_start, map.dram_bytes}, {16'hfb00, 11'h400});
   endtask : mp

   initial begin
      n_fail = 0;
      comparisons = 0;
      rst_b = 1'b0;
      req = '0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(16'hfff0, 8'hcf, 1'b1);
      rd(16'hfff4, 8'h0c, 1'b1);
      mp(1'b0, 16'h0, 1'b1, 1'b1);
      wr(16'hfff0, 8'hc8);
      rd(16'hfff0, 8'hc8, 1'b1);
      mp(1'b1, 16'h7fff, 1'b1, 1'b0);
      wr(16'hfff0, 8'hc6);
      mp(1'b1, 16'h5fff, 1'b1, 1'b0);
      wr(16'hfff0, 8'hff);
      rd(16'hfff0, 8'hef, 1'b1);
      mp(1'b0, 16'h0, 1'b0, 1'b1);
      wr(16'hfff0, 8'ha8);
      mp(1'b1, 16'h7fff, 1'b0, 1'b1);
      wr(16'hfff4, 8'hff);
      rd(16'hfff4, 8'h1f, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk({map.ext_valid, cfg_err}, 2'b01);
      wr(16'hfff4, 8'h0c);
      wr(16'hfff0, 8'hc8);
      mp(1'b1, 16'h7fff, 1'b1, 1'b0);
      chk({map.ext_valid, map.ext_bytes}, 17'h10000);
      rd(16'hfff2, 8'h00, 1'b0);
      // Second reset must discard the programmed capacity
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      rd(16'hfff0, 8'hcf, 1'b1);
      rd(16'hfff4, 8'h0c, 1'b1);
      mp(1'b0, 16'h0, 1'b1, 1'b1);
      report_and_stop();
   end

   initial begin
      #20000;
      n_fail++;
      report_and_stop();
   end
endmodule : test_memory_size_config
`default_nettype wire
